// [pkg/acs_pkg.sv]
// Shared constants, field layouts and state records of the conversion sequencer.
// Assumes a 20 MHz bus clock and a converter core that answers one comparator bit per tick.
package acs_pkg;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 50;
  localparam int ASYNC_START_NS = 5000;
  // Longest wait, so rounded down
  localparam int ASYNC_START_CYC = ASYNC_START_NS / CLK_PERIOD_NS;
  localparam logic [7:0] STARTUP_TICKS = 8'h03;
  localparam logic [7:0] SHORT_SAMPLE_TICKS = 8'h07;
  localparam logic [7:0] LONG_SAMPLE_TICKS = 8'h1B;

  // ------------------------------------------------------------
  // Encodings and reset values
  // ------------------------------------------------------------
  localparam logic [1:0] MODE_8BIT = 2'h0;
  localparam logic [1:0] MODE_10BIT = 2'h2;
  localparam logic [1:0] CLK_BUS = 2'h0;
  localparam logic [1:0] CLK_BUS_HALF = 2'h1;
  localparam logic [1:0] CLK_ALT = 2'h2;
  localparam logic [1:0] CLK_ASYNC = 2'h3;
  localparam logic [4:0] CHAN_OFF = 5'h1F;
  localparam logic [4:0] CHAN_RESET = 5'h1F;
  localparam logic [7:0] RESULT_RESET = 8'h00;
  localparam logic [9:0] COMPARE_RESET = 10'h000;
  localparam logic [10:0] DAC_FIRST = 11'h400;
  localparam logic [3:0] BIT_FIRST = 4'hA;
  localparam logic [3:0] BIT_LAST_10 = 4'h0;
  localparam logic [3:0] BIT_LAST_8 = 4'h2;

  // ------------------------------------------------------------
  // Register fields
  // ------------------------------------------------------------
  typedef struct packed {
    logic doneIrqEnable;
    logic continuousEnable;
    logic [4:0] channelSelect;
  } acs_sc1_type;

  typedef struct packed {
    logic hwTriggerSelect;
    logic compareEnable;
    logic compareGreaterSel;
  } acs_sc2_type;

  typedef struct packed {
    logic lowPowerCfg;
    logic [1:0] clockDivideSel;
    logic longSampleSel;
    logic [1:0] mode;
    logic [1:0] inputClockSel;
  } acs_cfg_type;

  // ------------------------------------------------------------
  // State records
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ST_IDLE, ST_WARM, ST_SAMPLE, ST_CONV} acs_phase_type;

  typedef struct packed {
    acs_phase_type phase;
    logic [7:0] cnt;
    logic [3:0] bitIdx;
    logic [10:0] dac;
    logic sampleOn;
    acs_sc1_type sc1;
    acs_sc2_type sc2;
    acs_cfg_type cfg;
    logic [9:0] compareVal;
    logic [7:0] resHigh;
    logic [7:0] resLow;
    logic done;
    logic irq;
    logic block;
    logic trigPrev;
    logic active;
    logic asyncEn;
  } acs_seq_type;

  typedef struct packed {
    logic half;
    logic [2:0] cnt;
    logic tick;
  } acs_div_type;

endpackage

// [logic/acs_clock_divider.sv]
// Converter clock tick generator: picks a source tick and divides it by 1, 2, 4 or 8.
// Assumes alternate and asynchronous ticks arrive as one-cycle pulses on the bus clock.
`timescale 1ns/100ps
module acs_clock_divider (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Control
  input wire logic enable,
  input wire logic [1:0] sourceSel,
  input wire logic [1:0] divideSel,
  // Source ticks
  input wire logic altTick,
  input wire logic asyncTick,
  // Divided tick
  output logic adckTick
);

  acs_pkg::acs_div_type s_q;
  acs_pkg::acs_div_type s_d;
  logic srcTick;

  always_comb
  begin
    s_d = s_q;
    s_d.tick = 1'b0;
    case (sourceSel)
      acs_pkg::CLK_BUS: srcTick = 1'b1;
      acs_pkg::CLK_BUS_HALF: srcTick = s_q.half;
      acs_pkg::CLK_ALT: srcTick = altTick;
      default: srcTick = asyncTick;
    endcase
    // Held in phase while idle so every conversion starts from a full period
    if (!enable)
    begin
      s_d.half = 1'b0;
      s_d.cnt = 3'h0;
    end
    else
    begin
      s_d.half = ~s_q.half;
      if (srcTick)
      begin
        if (s_q.cnt == 3'(({2'h0, 1'b1} << divideSel) - 3'h1))
        begin
          s_d.cnt = 3'h0;
          s_d.tick = 1'b1;
        end
        else
        begin
          s_d.cnt = s_q.cnt + 3'h1;
        end
      end
    end
  end

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      s_q <= '0;
    else
      s_q <= s_d;
  end

  assign adckTick = s_q.tick;

endmodule // acs_clock_divider

// [logic/acs_compare_unit.sv]
// Automatic compare: difference against the limit and the limit condition.
// Purely combinational; the caller masks the limit to the active resolution and rounds the result to it.
`timescale 1ns/100ps
module acs_compare_unit #(
  parameter int W = 10
) (
  // Operands
  input wire logic [W-1:0] result,
  input wire logic [W-1:0] limit,
  input wire logic greaterSel,
  // Outputs
  output logic [W-1:0] difference,
  output logic condition
);

  // Sum with the two's complement of the limit
  assign difference = W'(result + (~limit) + W'(1));
  assign condition = greaterSel ? (result >= limit) : (result < limit);

endmodule // acs_compare_unit

// [logic/acs_conversion_sequencer.sv]
// Conversion sequencer of a successive-approximation converter: start, abort,
// sample and approximation timing, result transfer with read blocking and compare.
// Assumes register writes and reads arrive as one-cycle strobes on mclk and that
// the analog core returns cmpIn high when the input is at or above dacCode.
//
// Contract
// - Software write to control one starts conversion
// - Hardware trigger event starts conversion
// - Continuous mode restarts after result transfer
// - Continuous runs until abort, after first start
// - Completion stores result, sets done, maybe interrupt
// - Half-read 10-bit result blocks new result
// - Blocked transfer restarts, except single failed compare
// - Control one write aborts then restarts
// - Other configuration writes abort conversion
// - Reset or stop without async clock aborts
// - Abort keeps results; reset clears them
// - Idle until started; async clock only when needed
// - Sample, then approximate, then transfer
// - First conversion within table cycle limits
// - Async clock adds up to 5 us startup
// - Subsequent continuous conversions within shorter limits
// - Compare stores result minus compare value
// - Greater select chooses at-or-above versus below
// - Failed compare sets no flag, stores nothing
// - Wait mode lets conversions complete and start
// - Bus, half bus, async clocks usable in wait
// - Rising trigger edge; edges ignored while converting
// - Rounded to 10 or 8 result bits
// - Disabled in reset or channel all ones
`timescale 1ns/100ps
module acs_conversion_sequencer #(
  parameter int ASYNC_START_CYCLES = acs_pkg::ASYNC_START_CYC
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register writes
  input wire logic sc1Wr,
  input wire acs_pkg::acs_sc1_type sc1Data,
  input wire logic sc2Wr,
  input wire acs_pkg::acs_sc2_type sc2Data,
  input wire logic cfgWr,
  input wire acs_pkg::acs_cfg_type cfgData,
  input wire logic cvHighWr,
  input wire logic cvLowWr,
  input wire logic [7:0] cvData,
  // Result reads
  input wire logic rdHigh,
  input wire logic rdLow,
  // System
  input wire logic stopMode,
  input wire logic hwTriggerInput,
  input wire logic altTick,
  input wire logic asyncTick,
  // Analog core
  input wire logic cmpIn,
  output logic sampleOn,
  output logic [10:0] dacCode,
  output logic lowPowerEn,
  // Status
  output logic [7:0] resultHigh,
  output logic [7:0] resultLow,
  output logic conversionDoneFlag,
  output logic doneIrq,
  output logic convActive,
  output logic asyncClkEn
);

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic chanOff(input logic [4:0] c);
    chanOff = (c == acs_pkg::CHAN_OFF);
  endfunction

  function automatic logic [7:0] sampleLen(input acs_pkg::acs_cfg_type c);
    sampleLen = c.longSampleSel ? acs_pkg::LONG_SAMPLE_TICKS
                                : acs_pkg::SHORT_SAMPLE_TICKS;
  endfunction

  // Rounds the 11-bit or 9-bit approximation to 10 or 8 bits, saturating at full scale
  function automatic logic [9:0] roundResult(input logic [10:0] code, input logic [1:0] mode);
    logic [11:0] sum11;
    logic [9:0] sum9;
    sum11 = {1'b0, code} + 12'h001;
    sum9 = {1'b0, code[10:2]} + 10'h001;
    if (mode == acs_pkg::MODE_10BIT)
      roundResult = (code == 11'h7FF) ? 10'h3FF : sum11[10:1];
    else
      roundResult = (code[10:2] == 9'h1FF) ? 10'h0FF : {2'h0, sum9[8:1]};
  endfunction

  // ------------------------------------------------------------
  // State and datapath
  // ------------------------------------------------------------
  acs_pkg::acs_seq_type s_q;
  acs_pkg::acs_seq_type s_d;
  logic adckTick;
  logic is10;
  logic [9:0] bitMask;
  logic [10:0] kept;
  logic [9:0] rounded;
  logic [9:0] limit;
  logic [9:0] diff;
  logic cond;

  assign is10 = (s_q.cfg.mode == acs_pkg::MODE_10BIT);
  assign bitMask = is10 ? 10'h3FF : 10'h0FF;
  // Trial bit kept when the input is at or above the trial level
  assign kept = cmpIn ? s_q.dac : (s_q.dac & ~(11'h001 << s_q.bitIdx));
  assign rounded = roundResult(kept, s_q.cfg.mode);
  assign limit = s_q.compareVal & bitMask;

  acs_clock_divider u_div (
    .mclk(mclk),
    .rst_b(rst_b),
    .enable(s_q.active),
    .sourceSel(s_q.cfg.inputClockSel),
    .divideSel(s_q.cfg.clockDivideSel),
    .altTick(altTick),
    .asyncTick(asyncTick),
    .adckTick(adckTick)
  );

  acs_compare_unit #(
    .W(10)
  ) u_cmp (
    .result(rounded),
    .limit(limit),
    .greaterSel(s_q.sc2.compareGreaterSel),
    .difference(diff),
    .condition(cond)
  );

  // ------------------------------------------------------------
  // Next state
  // ------------------------------------------------------------
  logic lastBit;
  logic condOk;
  logic isAsync;
  logic trigEdge;
  logic startConv;
  logic doneSet;
  logic [9:0] stored;

  always_comb
  begin
    s_d = s_q;
    lastBit = 1'b0;
    condOk = 1'b0;
    doneSet = 1'b0;
    startConv = 1'b0;
    stored = 10'h000;
    isAsync = (s_q.cfg.inputClockSel == acs_pkg::CLK_ASYNC);
    trigEdge = hwTriggerInput & ~s_q.trigPrev;
    s_d.trigPrev = hwTriggerInput;

    // Blocking follows the reads only; reads leave the conversion alone
    if (rdLow)
      s_d.block = 1'b0;
    else if (rdHigh && is10)
      s_d.block = 1'b1;
    if (rdLow)
      s_d.done = 1'b0;

    case (s_q.phase)
      acs_pkg::ST_IDLE:
      begin
        // Hardware trigger only observed while idle, so continuous runs see one edge
        if (s_q.sc2.hwTriggerSelect && trigEdge && !chanOff(s_q.sc1.channelSelect))
          startConv = 1'b1;
      end
      acs_pkg::ST_WARM:
      begin
        // Async generator warm-up counts bus cycles; others count converter ticks
        if (isAsync || adckTick)
        begin
          if (s_q.cnt <= 8'h01)
          begin
            s_d.phase = acs_pkg::ST_SAMPLE;
            s_d.cnt = sampleLen(s_q.cfg);
            s_d.sampleOn = 1'b1;
          end
          else
          begin
            s_d.cnt = s_q.cnt - 8'h01;
          end
        end
      end
      acs_pkg::ST_SAMPLE:
      begin
        if (adckTick)
        begin
          if (s_q.cnt <= 8'h01)
          begin
            // Input isolated before the approximation starts
            s_d.phase = acs_pkg::ST_CONV;
            s_d.sampleOn = 1'b0;
            s_d.dac = acs_pkg::DAC_FIRST;
            s_d.bitIdx = acs_pkg::BIT_FIRST;
          end
          else
          begin
            s_d.cnt = s_q.cnt - 8'h01;
          end
        end
      end
      acs_pkg::ST_CONV:
      begin
        if (adckTick)
        begin
          lastBit = (s_q.bitIdx == (is10 ? acs_pkg::BIT_LAST_10 : acs_pkg::BIT_LAST_8));
          if (!lastBit)
          begin
            s_d.bitIdx = s_q.bitIdx - 4'h1;
            s_d.dac = kept | (11'h001 << (s_q.bitIdx - 4'h1));
          end
          else
          begin
            condOk = !s_q.sc2.compareEnable || cond;
            stored = (s_q.sc2.compareEnable ? diff : rounded) & bitMask;
            s_d.dac = kept;
            s_d.phase = acs_pkg::ST_IDLE;
            if (condOk && !s_q.block)
            begin
              s_d.resHigh = is10 ? {6'h00, stored[9:8]} : acs_pkg::RESULT_RESET;
              s_d.resLow = stored[7:0];
              doneSet = 1'b1;
              if (s_q.sc1.continuousEnable)
                s_d.phase = acs_pkg::ST_SAMPLE;
            end
            else if (s_q.block)
            begin
              // Result lost; a single failed compare simply ends
              if (s_q.sc1.continuousEnable || !s_q.sc2.compareEnable || cond)
                s_d.phase = acs_pkg::ST_SAMPLE;
            end
            else if (s_q.sc1.continuousEnable)
            begin
              s_d.phase = acs_pkg::ST_SAMPLE;
            end
            if (s_d.phase == acs_pkg::ST_SAMPLE)
            begin
              s_d.cnt = sampleLen(s_q.cfg);
              s_d.sampleOn = 1'b1;
            end
          end
        end
      end
      default:
      begin
        s_d.phase = acs_pkg::ST_IDLE;
      end
    endcase

    // Configuration writes invalidate the running conversion; results stay
    if (sc2Wr)
      s_d.sc2 = sc2Data;
    if (cfgWr)
      s_d.cfg = cfgData;
    if (cvHighWr)
      s_d.compareVal[9:8] = cvData[1:0];
    if (cvLowWr)
      s_d.compareVal[7:0] = cvData;
    if (sc2Wr || cfgWr || cvHighWr || cvLowWr || sc1Wr)
    begin
      s_d.phase = acs_pkg::ST_IDLE;
      s_d.sampleOn = 1'b0;
      startConv = 1'b0;
      doneSet = 1'b0;
      s_d.done = 1'b0;
    end
    if (sc1Wr)
    begin
      s_d.sc1 = sc1Data;
      if (!chanOff(sc1Data.channelSelect) && !s_d.sc2.hwTriggerSelect)
        startConv = 1'b1;
    end
    // Channel all ones holds the converter disabled
    if (chanOff(s_d.sc1.channelSelect))
    begin
      s_d.phase = acs_pkg::ST_IDLE;
      s_d.sampleOn = 1'b0;
      startConv = 1'b0;
    end

    // First conversion after a start carries the startup overhead
    if (startConv)
    begin
      s_d.phase = acs_pkg::ST_WARM;
      s_d.sampleOn = 1'b0;
      if (s_d.cfg.inputClockSel == acs_pkg::CLK_ASYNC)
        s_d.cnt = 8'(ASYNC_START_CYCLES);
      else
        s_d.cnt = acs_pkg::STARTUP_TICKS;
    end

    // Stop without the async clock aborts; wait mode needs nothing here
    if (stopMode && s_d.cfg.inputClockSel != acs_pkg::CLK_ASYNC)
    begin
      s_d.phase = acs_pkg::ST_IDLE;
      s_d.sampleOn = 1'b0;
    end

    // Completion wins over a same-cycle read clear
    if (doneSet)
      s_d.done = 1'b1;
    s_d.irq = s_d.done && s_d.sc1.doneIrqEnable;
    s_d.active = (s_d.phase != acs_pkg::ST_IDLE);
    s_d.asyncEn = s_d.active && (s_d.cfg.inputClockSel == acs_pkg::CLK_ASYNC);
  end

  // ------------------------------------------------------------
  // Registers
  // ------------------------------------------------------------
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      s_q <= '0;
      s_q.phase <= acs_pkg::ST_IDLE;
      s_q.sc1.channelSelect <= acs_pkg::CHAN_RESET;
      s_q.compareVal <= acs_pkg::COMPARE_RESET;
      s_q.resHigh <= acs_pkg::RESULT_RESET;
      s_q.resLow <= acs_pkg::RESULT_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign sampleOn = s_q.sampleOn;
  assign dacCode = s_q.dac;
  assign lowPowerEn = s_q.cfg.lowPowerCfg;
  assign resultHigh = s_q.resHigh;
  assign resultLow = s_q.resLow;
  assign conversionDoneFlag = s_q.done;
  assign doneIrq = s_q.irq;
  assign convActive = s_q.active;
  assign asyncClkEn = s_q.asyncEn;

endmodule // acs_conversion_sequencer

// [tb/acs_seq_properties.sv]
// Concurrent checks on the conversion sequencer top-level ports.
// Assumes one mclk domain; mirrors the control fields from write strobes.
`timescale 1ns/100ps
module acs_seq_properties #(
  parameter int ASYNC_START_CYCLES = 100
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register writes
  input wire logic sc1Wr,
  input wire acs_pkg::acs_sc1_type sc1Data,
  input wire logic sc2Wr,
  input wire acs_pkg::acs_sc2_type sc2Data,
  input wire logic cfgWr,
  input wire acs_pkg::acs_cfg_type cfgData,
  input wire logic cvHighWr,
  input wire logic cvLowWr,
  // System
  input wire logic stopMode,
  input wire logic hwTriggerInput,
  // Status
  input wire logic [7:0] resultHigh,
  input wire logic [7:0] resultLow,
  input wire logic conversionDoneFlag,
  input wire logic doneIrq,
  input wire logic convActive,
  input wire logic asyncClkEn
);
  // ------
  // Mirrored fields
  // ------
  logic hwSel_q;
  logic ien_q;
  logic [4:0] chan_q;
  logic [1:0] clkSel_q;
  logic anyWr;
  assign anyWr = sc2Wr || cfgWr || cvHighWr || cvLowWr;
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      hwSel_q <= 1'h0;
      ien_q <= 1'h0;
      chan_q <= acs_pkg::CHAN_RESET;
      clkSel_q <= acs_pkg::CLK_BUS;
    end
    else
    begin
      if (sc2Wr)
        hwSel_q <= sc2Data.hwTriggerSelect;
      if (sc1Wr)
        ien_q <= sc1Data.doneIrqEnable;
      if (sc1Wr)
        chan_q <= sc1Data.channelSelect;
      if (cfgWr)
        clkSel_q <= cfgData.inputClockSel;
    end
  end

  // ------
  // Properties
  // ------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  chan_off_a: assert property (
    sc1Wr && sc1Data.channelSelect == acs_pkg::CHAN_OFF |=> !convActive)
    else $error("Channel off left converter active");
  sw_start_a: assert property (
    sc1Wr && !anyWr && !stopMode && !hwSel_q && sc1Data.channelSelect != acs_pkg::CHAN_OFF
    |=> convActive) else $error("Control write did not start");
  hw_start_a: assert property (
    !convActive && hwSel_q && $rose(hwTriggerInput) && chan_q != acs_pkg::CHAN_OFF
    && !sc1Wr && !anyWr && !stopMode |=> convActive) else $error("Trigger did not start");
  idle_hold_a: assert property (
    !convActive && !sc1Wr && !$rose(hwTriggerInput) |=> !convActive)
    else $error("Left idle without a start");
  wr_abort_a: assert property (
    anyWr && !sc1Wr |=> !convActive && !conversionDoneFlag)
    else $error("Write did not abort");
  result_hold_a: assert property (
    $changed(resultLow) || $changed(resultHigh) |-> conversionDoneFlag)
    else $error("Result changed without done");
  irq_level_a: assert property (
    doneIrq == (conversionDoneFlag && ien_q)) else $error("Interrupt level wrong");
  stop_abort_a: assert property (
    stopMode && clkSel_q != acs_pkg::CLK_ASYNC && !sc1Wr |=> !convActive)
    else $error("Stop did not abort");
  async_gate_a: assert property (
    asyncClkEn |-> convActive && clkSel_q == acs_pkg::CLK_ASYNC)
    else $error("Async clock enabled when unneeded");
endmodule // acs_seq_properties

bind acs_conversion_sequencer acs_seq_properties #(
  .ASYNC_START_CYCLES(ASYNC_START_CYCLES)
) acs_seq_properties_i (
  .mclk(mclk), .rst_b(rst_b), .sc1Wr(sc1Wr), .sc1Data(sc1Data), .sc2Wr(sc2Wr),
  .sc2Data(sc2Data), .cfgWr(cfgWr), .cfgData(cfgData), .cvHighWr(cvHighWr),
  .cvLowWr(cvLowWr), .stopMode(stopMode), .hwTriggerInput(hwTriggerInput),
  .resultHigh(resultHigh), .resultLow(resultLow), .conversionDoneFlag(conversionDoneFlag),
  .doneIrq(doneIrq), .convActive(convActive), .asyncClkEn(asyncClkEn)
);

// [tb/acs_conversion_sequencer_tb_top.sv]
// Directed self-checking bench of the conversion sequencer.
// Drives inputs on the falling edge; the comparator is modelled from ain.
`timescale 1ns/100ps
module acs_conversion_sequencer_tb_top;
  // ------
  // Signals
  // ------
  logic mclk = 1'h0, rst_b = 1'h0, sc1Wr = 1'h0, sc2Wr = 1'h0, cfgWr = 1'h0;
  logic cvHighWr = 1'h0, cvLowWr = 1'h0, rdHigh = 1'h0, rdLow = 1'h0, tk = 1'h0;
  logic stopMode = 1'h0, hwTriggerInput = 1'h0, cmpIn = 1'h0;
  int sampleCyc = 0;
  acs_pkg::acs_sc1_type sc1Data = 7'h1F;
  acs_pkg::acs_sc2_type sc2Data = 3'h0;
  acs_pkg::acs_cfg_type cfgData = 8'h00;
  logic [7:0] cvData = 8'h00, resultHigh, resultLow;
  logic [10:0] ain = 11'h000, dacCode;
  logic sampleOn, lowPowerEn, conversionDoneFlag, doneIrq, convActive, asyncClkEn;
  int error_cnt = 0, total_checks = 0;

  acs_conversion_sequencer #(.ASYNC_START_CYCLES(4)) acs_conversion_sequencer_i (
    .mclk(mclk), .rst_b(rst_b), .sc1Wr(sc1Wr), .sc1Data(sc1Data), .sc2Wr(sc2Wr),
    .sc2Data(sc2Data), .cfgWr(cfgWr), .cfgData(cfgData), .cvHighWr(cvHighWr),
    .cvLowWr(cvLowWr), .cvData(cvData), .rdHigh(rdHigh), .rdLow(rdLow),
    .stopMode(stopMode), .hwTriggerInput(hwTriggerInput), .altTick(tk), .asyncTick(tk),
    .cmpIn(cmpIn), .sampleOn(sampleOn), .dacCode(dacCode), .lowPowerEn(lowPowerEn),
    .resultHigh(resultHigh), .resultLow(resultLow), .conversionDoneFlag(conversionDoneFlag),
    .doneIrq(doneIrq), .convActive(convActive), .asyncClkEn(asyncClkEn));

  initial
    forever #25 mclk = ~mclk;
  always @(negedge mclk)
  begin
    tk <= ~tk;
    cmpIn <= ain >= dacCode;
    // Sampling window length in bus cycles, read as differences by the scenarios
    if (sampleOn === 1'h1)
      sampleCyc <= sampleCyc + 1;
  end

  // ------
  // Shared tasks
  // ------
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("Checks %0d errors %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task automatic pulse(ref logic s);
    s = 1'h1;
    @(negedge mclk);
    s = 1'h0;
  endtask
  // Kind 1 control one, 2 control two, 3 config, 4/5 compare high/low
  task automatic wr(input int k, input logic [9:0] v);
    sc1Data = v[6:0];
    sc2Data = v[2:0];
    cfgData = v[7:0];
    cvData = (k == 4) ? {6'h00, v[9:8]} : v[7:0];
    case (k)
      1: pulse(sc1Wr);
      2: pulse(sc2Wr);
      3: pulse(cfgWr);
      4: pulse(cvHighWr);
      default: pulse(cvLowWr);
    endcase
  endtask
  task automatic waitDone(output int n);
    n = 0;
    while (conversionDoneFlag !== 1'h1)
    begin
      @(negedge mclk);
      n++;
      if (n > 300)
      begin
        error_cnt++;
        test_done();
      end
    end
  endtask
  function automatic logic [15:0] rnd(input logic [10:0] a, input logic m10);
    logic [11:0] s;
    s = (m10 ? {1'h0, a} : {3'h0, a[10:2]}) + 12'h001;
    s = s >> 1;
    if (m10)
      return (s > 12'h3FF) ? 16'h03FF : {6'h00, s[9:0]};
    return (s > 12'h0FF) ? 16'h00FF : {6'h00, s[9:0]};
  endfunction

  // ------
  // Scenarios
  // ------
  task automatic t_modes;
    // Last two: half bus clock divided by two, then the alternate tick source
    logic [9:0] cfg [6] = '{10'h000, 10'h008, 10'h010, 10'h018, 10'h021, 10'h002};
    logic [10:0] av [6] = '{11'h7FF, 11'h7FF, 11'h2A5, 11'h2A5, 11'h155, 11'h6D2};
    int lim [6] = '{25, 28, 45, 48, 85, 45};
    int per [6] = '{1, 1, 1, 1, 4, 2};
    int n;
    int s0;
    for (int i = 0; i < 6; i++)
    begin
      ain = av[i];
      wr(3, cfg[i]);
      s0 = sampleCyc;
      wr(1, i[0] ? 10'h041 : 10'h001);
      waitDone(n);
      chk(n <= lim[i], 1'h1);
      chk({resultHigh, resultLow}, rnd(ain, cfg[i][3]));
      chk(doneIrq, i[0]);
      chk(16'(sampleCyc - s0), 16'(per[i] * (cfg[i][4] ? acs_pkg::LONG_SAMPLE_TICKS
                                              : acs_pkg::SHORT_SAMPLE_TICKS)));
      chk(dacCode, cfg[i][3] ? ain : (ain & 11'h7FC));
      @(negedge mclk);
      chk(convActive, 1'h0);
    end
  endtask
  task automatic t_abort;
    logic [15:0] keep;
    wr(1, 10'h01F);
    repeat (4) @(negedge mclk);
    chk(convActive, 1'h0);
    for (int k = 2; k < 6; k++)
    begin
      wr(3, 10'h008);
      keep = {resultHigh, resultLow};
      wr(1, 10'h001);
      repeat (8) @(negedge mclk);
      wr(k, 10'h008);
      chk(convActive, 1'h0);
      repeat (30) @(negedge mclk);
      chk({resultHigh, resultLow}, keep);
    end
  endtask
  task automatic t_restart_cont;
    int n;
    wr(1, 10'h001);
    repeat (8) @(negedge mclk);
    ain = 11'h155;
    wr(1, 10'h001);
    waitDone(n);
    chk({resultHigh, resultLow}, rnd(11'h155, 1'h1));
    wr(1, 10'h021);
    waitDone(n);
    ain = 11'h3C3;
    pulse(rdLow);
    waitDone(n);
    chk(n <= 20, 1'h1);
    chk({resultHigh, resultLow}, rnd(11'h3C3, 1'h1));
    wr(2, 10'h000);
    chk(convActive, 1'h0);
  endtask
  task automatic t_block;
    int n;
    wr(1, 10'h001);
    pulse(rdHigh);
    ain = 11'h111;
    repeat (40) @(negedge mclk);
    chk(convActive, 1'h1);
    chk(conversionDoneFlag, 1'h0);
    chk({resultHigh, resultLow}, rnd(11'h3C3, 1'h1));
    pulse(rdLow);
    waitDone(n);
    chk({resultHigh, resultLow}, rnd(11'h111, 1'h1));
  endtask
  task automatic t_compare;
    int n;
    wr(4, 10'h100);
    wr(5, 10'h100);
    wr(2, 10'h003);
    ain = 11'h1FF;
    wr(1, 10'h001);
    waitDone(n);
    chk({resultHigh, resultLow}, 16'h0000);
    ain = 11'h0FF;
    wr(1, 10'h001);
    repeat (40) @(negedge mclk);
    chk(conversionDoneFlag, 1'h0);
    chk({resultHigh, resultLow}, 16'h0000);
    wr(2, 10'h002);
    wr(1, 10'h001);
    waitDone(n);
    chk({resultHigh, resultLow}, 16'h0380);
  endtask
  task automatic t_hw;
    int n;
    wr(2, 10'h004);
    wr(1, 10'h001);
    repeat (3) @(negedge mclk);
    chk(convActive, 1'h0);
    hwTriggerInput = 1'h1;
    @(negedge mclk);
    chk(convActive, 1'h1);
    hwTriggerInput = 1'h0;
    repeat (10) @(negedge mclk);
    hwTriggerInput = 1'h1;
    waitDone(n);
    chk(n <= 15, 1'h1);
    hwTriggerInput = 1'h0;
  endtask
  task automatic t_stop;
    int n;
    wr(2, 10'h000);
    wr(1, 10'h001);
    repeat (8) @(negedge mclk);
    stopMode = 1'h1;
    @(negedge mclk);
    chk(convActive, 1'h0);
    stopMode = 1'h0;
    ain = 11'h2A5;
    wr(3, 10'h08B);
    chk(lowPowerEn, 1'h1);
    wr(1, 10'h001);
    chk(asyncClkEn, 1'h1);
    stopMode = 1'h1;
    waitDone(n);
    chk(n <= 55, 1'h1);
    chk({resultHigh, resultLow}, rnd(ain, 1'h1));
    stopMode = 1'h0;
    @(negedge mclk);
    chk(asyncClkEn, 1'h0);
    rst_b = 1'h0;
    @(negedge mclk);
    chk({resultHigh, resultLow}, 16'h0000);
    rst_b = 1'h1;
  endtask

  initial
  begin
    repeat (3) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'h1;
    @(negedge mclk);
    t_modes();
    t_abort();
    t_restart_cont();
    t_block();
    t_compare();
    t_hw();
    t_stop();
    test_done();
  end
endmodule // acs_conversion_sequencer_tb_top
